// >>> rtl/spr_pkg.sv
// Purpose: Shared constants and types for the serial port receive, mode and address block.
// Assumes: Registers are 32-bit APB words at byte address four times the register index.
// Notes:   Field positions of the serial control byte are fixed by the packed struct order.
package spr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          APB_ADDR_W         = 12;
	localparam logic [7:0]  SLAVE_ADDRESS_IDX  = 8'ha9;
	localparam logic [7:0]  ADDRESS_MASK_IDX   = 8'hb9;
	localparam logic [7:0]  SERIAL_CONTROL_IDX = 8'h10;
	localparam logic [7:0]  POWER_CONTROL_IDX  = 8'h11;
	localparam logic [7:0]  SERIAL_BUFFER_IDX  = 8'h12;

	// Power control field positions.
	localparam int          PC_RATE_DOUBLE     = 7;
	localparam int          PC_FE_SELECT       = 6;
	localparam int          PC_TIMER2_SEL      = 0;

	// Reset values.
	localparam logic [7:0]  CONTROL_RESET      = 8'h00;
	localparam logic [7:0]  ADDRESS_RESET      = 8'h00;
	localparam logic [7:0]  MASK_RESET         = 8'h00;
	localparam logic [31:0] READ_RESET         = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Modes and timing counts in oscillator clocks
	// ----------------------------------------------------------------
	localparam logic [1:0]  MODE_SYNC          = 2'h0;
	localparam logic [1:0]  MODE_ASYNC10       = 2'h1;
	localparam logic [1:0]  MODE_ASYNC11_FIXED = 2'h2;
	localparam logic [1:0]  MODE_ASYNC11_TIMER = 2'h3;
	localparam logic [3:0]  M0_PERIOD_SLOW     = 4'hc;
	localparam logic [3:0]  M0_PERIOD_FAST     = 4'h4;
	localparam logic [3:0]  M0_FALL_SLOW       = 4'h3;
	localparam logic [3:0]  M0_RISE_SLOW       = 4'h9;
	localparam logic [3:0]  M0_FALL_FAST       = 4'h1;
	localparam logic [3:0]  M0_RISE_FAST       = 4'h3;
	localparam logic [2:0]  M2_TICK_SLOW       = 3'h4;
	localparam logic [2:0]  M2_TICK_FAST       = 3'h2;
	localparam logic [3:0]  SLICE_LAST         = 4'hf;
	localparam logic [3:0]  SAMPLE_A           = 4'h7;
	localparam logic [3:0]  SAMPLE_B           = 4'h8;
	localparam logic [3:0]  SAMPLE_C           = 4'h9;
	localparam logic [3:0]  STOP_IDX_10        = 4'h9;
	localparam logic [3:0]  STOP_IDX_11        = 4'ha;
	localparam logic [3:0]  FRAME_BITS_10      = 4'ha;
	localparam logic [3:0]  FRAME_BITS_11      = 4'hb;
	localparam logic [3:0]  SYNC_BITS          = 4'h8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic modeBit0;
		logic modeBit1;
		logic multiprocessorEnable;
		logic receiveEnable;
		logic txNinthBit;
		logic rxNinthBit;
		logic txDoneFlag;
		logic rxDoneFlag;
	} spr_ctrl_t;

	typedef struct packed {
		logic                  psel;
		logic                  penable;
		logic                  pwrite;
		logic [APB_ADDR_W-1:0] paddr;
		logic [31:0]           pwdata;
	} spr_apb_req_t;

	typedef enum logic [1:0] {RX_IDLE, RX_RUN} spr_rx_state_t;
	typedef enum logic [1:0] {TX_IDLE, TX_RUN} spr_tx_state_t;
	typedef enum logic [1:0] {SY_IDLE, SY_TX, SY_RX} spr_sync_state_t;

endpackage

// >>> rtl/spr_serial_port.sv
// Purpose: Serial port with mode select, receive gating, framing error and address match.
// Assumes: Inputs are synchronous to mclk; timer overflow inputs are one-cycle strobes.
// Notes:   Registers sit on APB; every access takes one wait state.
`timescale 1ns/1ps

// Behaviour
// RQ1 - Complete frame only if done clear, gating passes
// RQ2 - Completion loads ninth bit, buffer, sets done
// RQ3 - After mid stop bit, watch for start
// RQ4 - Mode 3 equals mode 2, timer rate
// RQ5 - Buffer write always starts a transmission; in mode 0 the code starts one only when the shift engine is idle
// RQ6 - Mode 0 receive starts when enabled, idle
// RQ7 - Async receive starts on start bit, enabled
// RQ8 - Two mode bits select mode 0 to 3
// RQ9 - Frames are 8, 10 or 11 bits
// RQ10 - Bit clock 4/12 or 32/64, timers otherwise
// RQ11 - Missing valid stop bit sets framing error
// RQ12 - fe_select steers top control bit access
// RQ13 - Framing error sticky until software clears it
// RQ14 - Software sets fe_select to reach error
// RQ15 - Address bytes carry ninth bit one, matched
// RQ16 - Mode 1 gating needs stop one, match
// RQ17 - Given address compares only masked bits
// RQ18 - Broadcast address is address OR mask
// RQ19 - Address and mask reset to zero
// RQ20 - Slave software clears enable once addressed
// RQ21 - Software configures mode and timers first
// RQ22 - Mode 0 rate picked by multiprocessor bit
// RQ23 - Falling edge resets slices, vote three samples
// RQ24 - Invalid start bit aborts the reception
// RQ25 - Mode 1 rate from timer overflow divide
// RQ26 - Discarded frame leaves buffer, flags unchanged
// RQ27 - Stop bit is the voted mid value
module spr_serial_port (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// APB slave
	input  wire spr_pkg::spr_apb_req_t apbReq,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Timer overflow strobes
	input  wire logic                 timer1Overflow,
	input  wire logic                 timer2Overflow,
	// Serial pins
	input  wire logic                 rxdIn,
	output logic                      rxdOut,
	output logic                      rxdOe,
	output logic                      txdOut
);
	import spr_pkg::*;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Two-of-three vote rejects a single noisy sample.
	function automatic logic majority(input logic a, input logic b, input logic c);
		majority = (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic regHit(input logic [APB_ADDR_W-1:0] addr, input logic [7:0] idx);
		regHit = (addr == {2'h0, idx, 2'h0});
	endfunction

	// ----------------------------------------------------------------
	// State declarations
	// ----------------------------------------------------------------
	spr_ctrl_t       ctrl,          next_ctrl;
	logic            framingError,  next_framingError;
	logic            feSelect,      next_feSelect;
	logic            rateDouble,    next_rateDouble;
	logic            timer2Sel,     next_timer2Sel;
	logic [7:0]      slaveAddress,  next_slaveAddress;
	logic [7:0]      addressMask,   next_addressMask;
	logic [7:0]      rxBuffer,      next_rxBuffer;
	logic [31:0]     next_prdata;
	logic            next_pready,   next_pslverr;
	logic [2:0]      tickCnt,       next_tickCnt;
	logic            ovfHalf,       next_ovfHalf;
	spr_rx_state_t   rxState,       next_rxState;
	logic [3:0]      rxDiv,         next_rxDiv;
	logic [3:0]      rxBits,        next_rxBits;
	logic [8:0]      rxShift,       next_rxShift;
	logic [1:0]      rxVotes,       next_rxVotes;
	logic            rxdPrev,       next_rxdPrev;
	spr_tx_state_t   txState,       next_txState;
	logic [3:0]      txDiv,         next_txDiv;
	logic [3:0]      txLeft,        next_txLeft;
	logic [10:0]     txShift,       next_txShift;
	logic            txLine,        next_txLine;
	spr_sync_state_t syState,       next_syState;
	logic [3:0]      syPhase,       next_syPhase;
	logic [3:0]      syBits,        next_syBits;
	logic [7:0]      syShift,       next_syShift;
	logic            next_txdOut,   next_rxdOut,  next_rxdOe;

	// Events and decoded terms.
	logic [1:0]      mode;
	logic            asyncMode,     nineBit,      sampleTick;
	logic            busWrite,      busRead,      bufWrite;
	logic            rxLoad,        rxLoadNinth,  feSet,        txSetDone;
	logic [7:0]      rxLoadByte;
	logic            stopEval,      stopAllowed,  stopBit,      addrMatch;
	logic            syClkLow;
	logic [3:0]      syPeriod,      syFall,       syRise;

	// ----------------------------------------------------------------
	// Mode decode and bus decode
	// ----------------------------------------------------------------
	// The tabled-first bit is the low bit of the mode number.
	always_comb begin
		mode      = {ctrl.modeBit1, ctrl.modeBit0}; // RQ8
		asyncMode = (mode != MODE_SYNC); // RQ8
		nineBit   = (mode == MODE_ASYNC11_FIXED) || (mode == MODE_ASYNC11_TIMER); // RQ4 RQ9
		busWrite  = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;
		busRead   = apbReq.psel && apbReq.penable && !pready && !apbReq.pwrite;
		bufWrite  = busWrite && regHit(apbReq.paddr, SERIAL_BUFFER_IDX); // RQ5
	end

	// ----------------------------------------------------------------
	// Sixteen-times sample tick
	// ----------------------------------------------------------------
	// Mode 2 divides the oscillator; modes 1 and 3 take timer overflows, and timer 1
	// without rate doubling needs every second overflow for the slower rate.
	always_comb begin
		next_tickCnt = tickCnt + 3'h1;
		next_ovfHalf = ovfHalf;
		sampleTick   = 1'b0;
		if (mode == MODE_ASYNC11_FIXED) begin
			if (tickCnt >= (rateDouble ? M2_TICK_FAST : M2_TICK_SLOW) - 3'h1) begin // RQ10
				next_tickCnt = 3'h0;
				sampleTick   = 1'b1;
			end
		end else begin
			next_tickCnt = 3'h0;
			if (timer2Sel) begin
				sampleTick = timer2Overflow; // RQ25
			end else if (timer1Overflow) begin
				next_ovfHalf = !ovfHalf;
				sampleTick   = rateDouble || ovfHalf; // RQ25 RQ4
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			tickCnt <= 3'h0;
			ovfHalf <= 1'b0;
		end else begin
			tickCnt <= next_tickCnt;
			ovfHalf <= next_ovfHalf;
		end
	end

	// ----------------------------------------------------------------
	// Asynchronous receiver
	// ----------------------------------------------------------------
	// Given address: masked bits must equal. Broadcast: every one bit of the OR must be one.
	always_comb begin
		addrMatch = (((rxLoadByte ^ slaveAddress) & addressMask) == 8'h00) // RQ17
			|| (((rxLoadByte ^ (slaveAddress | addressMask))
			& (slaveAddress | addressMask)) == 8'h00); // RQ18
	end

	// The falling edge restarts the slice counter so slices line up with the bit.
	always_comb begin
		next_rxState = rxState;
		next_rxDiv   = rxDiv;
		next_rxBits  = rxBits;
		next_rxShift = rxShift;
		next_rxVotes = rxVotes;
		next_rxdPrev = rxdIn;
		stopEval     = 1'b0;
		stopBit      = majority(rxVotes[0], rxVotes[1], rxdIn); // RQ23 RQ27
		rxLoadByte   = nineBit ? rxShift[7:0] : rxShift[8:1];
		rxLoadNinth  = nineBit ? rxShift[8] : stopBit; // RQ2
		stopAllowed  = 1'b0;
		feSet        = 1'b0;
		case (rxState)
			RX_IDLE: begin
				if (asyncMode && ctrl.receiveEnable && rxdPrev && !rxdIn) begin // RQ7
					next_rxState = RX_RUN;
					next_rxDiv   = 4'h0; // RQ23
					next_rxBits  = 4'h0;
				end
			end
			RX_RUN: begin
				if (!asyncMode) begin
					next_rxState = RX_IDLE;
				end else if (sampleTick) begin
					next_rxDiv = rxDiv + 4'h1;
					if (rxDiv == SAMPLE_A) begin
						next_rxVotes[0] = rxdIn; // RQ23
					end
					if (rxDiv == SAMPLE_B) begin
						next_rxVotes[1] = rxdIn; // RQ23
					end
					if (rxDiv == SAMPLE_C) begin
						next_rxBits = rxBits + 4'h1;
						if (rxBits == 4'h0) begin
							if (stopBit) begin
								next_rxState = RX_IDLE; // RQ24
							end
						end else if (rxBits == (nineBit ? STOP_IDX_11 : STOP_IDX_10)) begin
							stopEval     = 1'b1;
							feSet        = !stopBit; // RQ11
							stopAllowed  = !ctrl.rxDoneFlag // RQ1
								&& (!ctrl.multiprocessorEnable
								|| (rxLoadNinth && addrMatch)); // RQ15 RQ16
							next_rxState = RX_IDLE; // RQ3
						end else begin
							next_rxShift = {stopBit, rxShift[8:1]};
						end
					end
				end
			end
			default: begin
				next_rxState = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rxState <= RX_IDLE;
			rxDiv   <= 4'h0;
			rxBits  <= 4'h0;
			rxShift <= 9'h000;
			rxVotes <= 2'h0;
			rxdPrev <= 1'b1;
		end else begin
			rxState <= next_rxState;
			rxDiv   <= next_rxDiv;
			rxBits  <= next_rxBits;
			rxShift <= next_rxShift;
			rxVotes <= next_rxVotes;
			rxdPrev <= next_rxdPrev;
		end
	end

	// ----------------------------------------------------------------
	// Asynchronous transmitter
	// ----------------------------------------------------------------
	// Bits leave on slice-counter rollovers; the write clears the counter, so the start is tied to the write.
	always_comb begin
		next_txState = txState;
		next_txDiv   = txDiv;
		next_txLeft  = txLeft;
		next_txShift = txShift;
		next_txLine  = txLine;
		txSetDone    = 1'b0;
		if (bufWrite && asyncMode) begin
			next_txState = TX_RUN; // RQ5
			next_txDiv   = 4'h0;
			next_txLeft  = nineBit ? FRAME_BITS_11 : FRAME_BITS_10; // RQ9
			next_txShift = nineBit ? {1'b1, ctrl.txNinthBit, apbReq.pwdata[7:0], 1'b0}
				: {2'h3, apbReq.pwdata[7:0], 1'b0};
		end else if (txState == TX_RUN && sampleTick) begin
			next_txDiv = txDiv + 4'h1;
			if (txDiv == SLICE_LAST) begin
				next_txLine  = txShift[0];
				next_txShift = {1'b1, txShift[10:1]};
				next_txLeft  = txLeft - 4'h1;
				if (txLeft == 4'h1) begin
					txSetDone    = 1'b1;
					next_txState = TX_IDLE;
				end
			end
		end else if (!asyncMode) begin
			next_txState = TX_IDLE;
			next_txLine  = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			txState <= TX_IDLE;
			txDiv   <= 4'h0;
			txLeft  <= 4'h0;
			txShift <= 11'h7ff;
			txLine  <= 1'b1;
		end else begin
			txState <= next_txState;
			txDiv   <= next_txDiv;
			txLeft  <= next_txLeft;
			txShift <= next_txShift;
			txLine  <= next_txLine;
		end
	end

	// ----------------------------------------------------------------
	// Mode 0 shift engine
	// ----------------------------------------------------------------
	// Half duplex: one engine serves both directions, a write wins over a pending receive.
	always_comb begin
		syPeriod     = ctrl.multiprocessorEnable ? M0_PERIOD_FAST : M0_PERIOD_SLOW; // RQ22
		syFall       = ctrl.multiprocessorEnable ? M0_FALL_FAST : M0_FALL_SLOW; // RQ10
		syRise       = ctrl.multiprocessorEnable ? M0_RISE_FAST : M0_RISE_SLOW; // RQ10
		syClkLow     = (syState != SY_IDLE) && (syPhase >= syFall) && (syPhase < syRise);
		next_syState = syState;
		next_syPhase = syPhase;
		next_syBits  = syBits;
		next_syShift = syShift;
		rxLoad       = stopAllowed; // RQ2
		case (syState)
			SY_IDLE: begin
				next_syPhase = 4'h0;
				next_syBits  = 4'h0;
				if (!asyncMode && bufWrite) begin
					next_syState = SY_TX; // RQ5
					next_syShift = apbReq.pwdata[7:0];
				end else if (!asyncMode && !ctrl.rxDoneFlag && ctrl.receiveEnable) begin
					next_syState = SY_RX; // RQ6
				end
			end
			SY_TX, SY_RX: begin
				next_syPhase = syPhase + 4'h1;
				if (syState == SY_RX && syPhase == syRise) begin
					next_syShift = {rxdIn, syShift[7:1]}; // RQ6
				end
				if (syPhase == syPeriod - 4'h1) begin
					next_syPhase = 4'h0;
					next_syBits  = syBits + 4'h1;
					if (syState == SY_TX) begin
						next_syShift = {1'b1, syShift[7:1]};
					end
					if (syBits == SYNC_BITS - 4'h1) begin // RQ9
						next_syState = SY_IDLE;
						rxLoad       = (syState == SY_RX);
					end
				end
				if (asyncMode) begin
					next_syState = SY_IDLE;
				end
			end
			default: begin
				next_syState = SY_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			syState <= SY_IDLE;
			syPhase <= 4'h0;
			syBits  <= 4'h0;
			syShift <= 8'h00;
		end else begin
			syState <= next_syState;
			syPhase <= next_syPhase;
			syBits  <= next_syBits;
			syShift <= next_syShift;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Registered pins cost one cycle of skew but keep the outputs glitch free.
	always_comb begin
		next_txdOut = asyncMode ? txLine : !syClkLow; // RQ6
		next_rxdOe  = !asyncMode && (syState == SY_TX);
		next_rxdOut = syShift[0];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			txdOut <= 1'b1;
			rxdOut <= 1'b1;
			rxdOe  <= 1'b0;
		end else begin
			txdOut <= next_txdOut;
			rxdOut <= next_rxdOut;
			rxdOe  <= next_rxdOe;
		end
	end

	// ----------------------------------------------------------------
	// Register file and APB slave
	// ----------------------------------------------------------------
	// Hardware sets are applied after software writes so a set is never lost.
	always_comb begin
		next_ctrl         = ctrl;
		next_framingError = framingError;
		next_feSelect     = feSelect;
		next_rateDouble   = rateDouble;
		next_timer2Sel    = timer2Sel;
		next_slaveAddress = slaveAddress;
		next_addressMask  = addressMask;
		next_rxBuffer     = rxBuffer;
		next_pready       = apbReq.psel && apbReq.penable && !pready;
		next_pslverr      = 1'b0;
		next_prdata       = prdata;
		if (busWrite && regHit(apbReq.paddr, SERIAL_CONTROL_IDX)) begin
			next_ctrl = spr_ctrl_t'(apbReq.pwdata[7:0]);
			if (feSelect) begin
				next_ctrl.modeBit0 = ctrl.modeBit0;
				next_framingError  = apbReq.pwdata[7]; // RQ12 RQ13
			end
		end
		if (busWrite && regHit(apbReq.paddr, POWER_CONTROL_IDX)) begin
			next_rateDouble = apbReq.pwdata[PC_RATE_DOUBLE];
			next_feSelect   = apbReq.pwdata[PC_FE_SELECT];
			next_timer2Sel  = apbReq.pwdata[PC_TIMER2_SEL];
		end
		if (busWrite && regHit(apbReq.paddr, SLAVE_ADDRESS_IDX)) begin
			next_slaveAddress = apbReq.pwdata[7:0];
		end
		if (busWrite && regHit(apbReq.paddr, ADDRESS_MASK_IDX)) begin
			next_addressMask = apbReq.pwdata[7:0];
		end
		if (rxLoad) begin
			// The last mode 0 bit may shift in the load cycle itself.
			next_rxBuffer        = asyncMode ? rxLoadByte : next_syShift; // RQ2
			next_ctrl.rxDoneFlag = 1'b1; // RQ2
			if (asyncMode) begin
				next_ctrl.rxNinthBit = rxLoadNinth; // RQ2
			end
		end
		if (txSetDone || (syState == SY_TX && next_syState == SY_IDLE && !asyncMode)) begin
			next_ctrl.txDoneFlag = 1'b1;
		end
		if (feSet) begin
			next_framingError = 1'b1; // RQ11
		end
		if (busRead) begin
			next_prdata = READ_RESET;
			if (regHit(apbReq.paddr, SERIAL_CONTROL_IDX)) begin
				next_prdata[7:0] = {feSelect ? framingError : ctrl.modeBit0, ctrl[6:0]}; // RQ12
			end else if (regHit(apbReq.paddr, POWER_CONTROL_IDX)) begin
				next_prdata[PC_RATE_DOUBLE] = rateDouble;
				next_prdata[PC_FE_SELECT]   = feSelect;
				next_prdata[PC_TIMER2_SEL]  = timer2Sel;
			end else if (regHit(apbReq.paddr, SLAVE_ADDRESS_IDX)) begin
				next_prdata[7:0] = slaveAddress;
			end else if (regHit(apbReq.paddr, ADDRESS_MASK_IDX)) begin
				next_prdata[7:0] = addressMask;
			end else if (regHit(apbReq.paddr, SERIAL_BUFFER_IDX)) begin
				next_prdata[7:0] = rxBuffer;
			end else begin
				next_pslverr = 1'b1;
			end
		end
		if (next_pready && apbReq.pwrite && !(regHit(apbReq.paddr, SERIAL_CONTROL_IDX)
			|| regHit(apbReq.paddr, POWER_CONTROL_IDX)
			|| regHit(apbReq.paddr, SLAVE_ADDRESS_IDX)
			|| regHit(apbReq.paddr, ADDRESS_MASK_IDX)
			|| regHit(apbReq.paddr, SERIAL_BUFFER_IDX))) begin
			next_pslverr = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl         <= spr_ctrl_t'(CONTROL_RESET);
			framingError <= 1'b0;
			feSelect     <= 1'b0;
			rateDouble   <= 1'b0;
			timer2Sel    <= 1'b0;
			slaveAddress <= ADDRESS_RESET; // RQ19
			addressMask  <= MASK_RESET; // RQ19
			rxBuffer     <= 8'h00;
			prdata       <= READ_RESET;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
		end else begin
			ctrl         <= next_ctrl;
			framingError <= next_framingError;
			feSelect     <= next_feSelect;
			rateDouble   <= next_rateDouble;
			timer2Sel    <= next_timer2Sel;
			slaveAddress <= next_slaveAddress;
			addressMask  <= next_addressMask;
			rxBuffer     <= next_rxBuffer;
			prdata       <= next_prdata;
			pready       <= next_pready;
			pslverr      <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------
	// Assertions and cover points
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_load_needs_clear: assert property (stopAllowed |-> !ctrl.rxDoneFlag) // RQ1
		else $error("Frame completed while receive done was set.");
	a_load_sets_done: assert property (rxLoad |=> ctrl.rxDoneFlag && rxBuffer == $past(rxLoadByte)
		|| !$past(asyncMode)) // RQ2
		else $error("Completed frame did not load buffer and set done.");
	a_discard_holds: assert property (stopEval && !stopAllowed |=> $stable(rxBuffer)) // RQ26
		else $error("Discarded frame changed the receive buffer.");
	a_stop_sets_fe: assert property (stopEval && !stopBit |=> framingError) // RQ11
		else $error("Bad stop bit did not set the framing error.");
	a_fe_stays_set: assert property (framingError && !(busWrite && feSelect)
		|=> framingError) // RQ13
		else $error("Framing error cleared without a software write.");
	a_bad_start_aborts: assert property (rxState == RX_RUN && rxBits == 4'h0 && sampleTick
		&& rxDiv == SAMPLE_C && stopBit |=> rxState == RX_IDLE) // RQ24
		else $error("Invalid start bit did not abort reception.");
	a_match_gate: assert property (stopAllowed && ctrl.multiprocessorEnable
		|-> addrMatch && rxLoadNinth) // RQ15
		else $error("Unmatched address completed with multiprocessor enable.");
	a_ren_blocks_rx: assert property (rxState == RX_IDLE && !ctrl.receiveEnable
		|=> rxState == RX_IDLE) // RQ7
		else $error("Receiver started while receive disabled.");
	a_tx_write_starts: assert property (bufWrite && asyncMode |=> txState == TX_RUN) // RQ5
		else $error("Buffer write did not start a transmission.");
	a_m0_slow_low: assert property (!asyncMode && !ctrl.multiprocessorEnable
		&& syState != SY_IDLE && syPhase == M0_FALL_SLOW && !bufWrite
		|-> syClkLow [*6] ##1 !syClkLow) // RQ22
		else $error("Slow mode 0 shift clock low time is not six clocks.");

	c_async_frame: cover property (stopAllowed);
	c_framing_error: cover property (feSet);
	c_sync_receive: cover property (rxLoad && !asyncMode);
	c_tx_done: cover property (txSetDone);

endmodule

// >>> verification/spr_far_node.sv
// Purpose: Far serial node that sends 11-bit frames or mode 0 bytes on the receive line.
// Assumes: Bit time is given in mclk cycles and the task is entered at a rising edge.
// Notes:   The line idles high, as a pulled-up wire would.
`timescale 1ns/1ps
module spr_far_node (
	// Clock and line
	input  wire logic mclk,
	input  wire logic shiftClk,
	output logic      rxdLine
);
	initial rxdLine = 1'b1;
	// Start bit first, data LSB first, ninth bit, then the chosen stop level.
	task automatic send(input logic [7:0] b, input logic n9, input logic stopBit, input int bitClk);
		logic [10:0] f;
		f = {stopBit, n9, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxdLine <= f[i];
			repeat (bitClk) @(posedge mclk);
		end
		rxdLine <= 1'b1;
		@(posedge mclk);
	endtask
	// Mode 0: each bit goes out on a falling shift clock edge.
	task automatic shift(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(negedge shiftClk);
			rxdLine <= b[i];
		end
		@(posedge shiftClk);
		rxdLine <= 1'b1;
	endtask
endmodule

// >>> verification/spr_serial_port_test.sv
// Purpose: Self-checking bench for the serial port block.
// Assumes: Mode 2 at the doubled rate, so one bit lasts 32 clocks.
// Notes:   Both timers overflow every second clock, so modes 1 and 3 also take 32 clocks.
`timescale 1ns/1ps
module spr_serial_port_test;
	import spr_pkg::*;
	logic         mclk, rst, pready, pslverr, rxdOut, rxdOe, txdOut, rxdLine, err;
	logic         timer1Overflow = 1'b0;
	logic         timer2Overflow = 1'b0;
	logic [31:0]  prdata, rd;
	spr_apb_req_t req;
	int           n_mismatch = 0;
	int           check_count = 0;
	logic [16:0]  rows [3] = '{{SLAVE_ADDRESS_IDX, 8'ha4, 1'b0}, {ADDRESS_MASK_IDX, 8'hfa, 1'b0},
		{8'h00, 8'h55, 1'b1}};
	logic [9:0]   adr [4] = '{{8'hb0, 2'b10}, {8'ha1, 2'b11}, {8'ha1, 2'b00}, {8'hfe, 2'b11}};
	wire logic    rxd = rxdOe ? rxdOut : rxdLine;

	spr_serial_port u_spr_serial_port (.mclk(mclk), .rst(rst), .apbReq(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer1Overflow(timer1Overflow),
		.timer2Overflow(timer2Overflow), .rxdIn(rxd), .rxdOut(rxdOut), .rxdOe(rxdOe),
		.txdOut(txdOut));
	spr_far_node u_spr_far_node (.mclk(mclk), .shiftClk(txdOut), .rxdLine(rxdLine));

	// A 40 ns clock.
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// One-cycle overflow strobes on every second clock.
	always @(posedge mclk) begin
		timer1Overflow <= !timer1Overflow;
		timer2Overflow <= !timer2Overflow;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, {2'h0, i, 2'h0}, {24'h0, d}};
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// A hang counts as a mismatch; the whole run needs about 3900 cycles.
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		close_out;
	end

	// Main sequence.
	initial begin
		int t;
		logic [7:0] bits;
		req = '0;
		rst = 1'b1;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		apb(0, SLAVE_ADDRESS_IDX, 8'h0);
		chk("addr reset", rd, 32'h0);
		apb(0, ADDRESS_MASK_IDX, 8'h0);
		chk("mask reset", rd, 32'h0);
		foreach (rows[k]) begin
			apb(1, rows[k][16:9], rows[k][8:1]);
			apb(0, rows[k][16:9], 8'h0);
			chk("reg read", rd, rows[k][0] ? 32'h0 : {24'h0, rows[k][8:1]});
			chk("slave error", {31'h0, err}, {31'h0, rows[k][0]});
		end
		$display("registers done");
		apb(1, POWER_CONTROL_IDX, 8'h80);
		apb(1, SERIAL_CONTROL_IDX, 8'h50);
		u_spr_far_node.send(8'ha0, 1'b1, 1'b1, 32);
		u_spr_far_node.send(8'h33, 1'b0, 1'b1, 32);
		apb(0, SERIAL_BUFFER_IDX, 8'h0);
		chk("buffer", rd, 32'ha0);
		apb(0, SERIAL_CONTROL_IDX, 8'h0);
		chk("control", rd, 32'h55);
		foreach (adr[k]) begin
			apb(1, SERIAL_CONTROL_IDX, 8'h70);
			u_spr_far_node.send(adr[k][9:2], adr[k][1], 1'b1, 32);
			apb(0, SERIAL_CONTROL_IDX, 8'h0);
			chk("match", {31'h0, rd[0]}, {31'h0, adr[k][0]});
		end
		$display("receive done");
		apb(1, SERIAL_CONTROL_IDX, 8'h50);
		apb(1, POWER_CONTROL_IDX, 8'hc0);
		u_spr_far_node.send(8'h11, 1'b0, 1'b0, 32);
		apb(0, SERIAL_CONTROL_IDX, 8'h0);
		chk("error set", rd, 32'hd1);
		apb(1, SERIAL_CONTROL_IDX, 8'hd0);
		u_spr_far_node.send(8'h22, 1'b0, 1'b1, 32);
		apb(0, SERIAL_CONTROL_IDX, 8'h0);
		chk("error kept", rd, 32'hd1);
		apb(1, SERIAL_CONTROL_IDX, 8'h50);
		apb(0, SERIAL_CONTROL_IDX, 8'h0);
		chk("error clear", rd, 32'h50);
		apb(1, POWER_CONTROL_IDX, 8'h81);
		apb(1, SERIAL_CONTROL_IDX, 8'hd0);
		u_spr_far_node.send(8'h3c, 1'b1, 1'b1, 32);
		apb(0, SERIAL_BUFFER_IDX, 8'h0);
		chk("m3 buffer", rd, 32'h3c);
		apb(0, SERIAL_CONTROL_IDX, 8'h0);
		chk("m3 control", rd, 32'hd5);
		apb(1, POWER_CONTROL_IDX, 8'h80);
		apb(1, SERIAL_CONTROL_IDX, 8'h90);
		u_spr_far_node.send(8'hc3, 1'b1, 1'b1, 32);
		apb(0, SERIAL_BUFFER_IDX, 8'h0);
		chk("m1 buffer", rd, 32'hc3);
		apb(0, SERIAL_CONTROL_IDX, 8'h0);
		chk("m1 control", rd, 32'h95);
		apb(1, SERIAL_CONTROL_IDX, 8'h00);
		apb(1, SERIAL_BUFFER_IDX, 8'ha5);
		for (int i = 0; i < 8; i++) begin
			@(posedge txdOut);
			bits = {rxdOut, bits[7:1]};
			chk("m0 drive", {31'h0, rxdOe}, 32'h1);
		end
		chk("m0 send", {24'h0, bits}, 32'ha5);
		apb(1, SERIAL_CONTROL_IDX, 8'h30);
		u_spr_far_node.shift(8'h96);
		apb(0, SERIAL_BUFFER_IDX, 8'h0);
		chk("m0 receive", rd, 32'h96);
		$display("modes done");
		apb(1, SERIAL_CONTROL_IDX, 8'h50);
		apb(1, SERIAL_BUFFER_IDX, 8'h5a);
		t = 0;
		while (txdOut !== 1'b0 && t < 40) begin
			@(posedge mclk);
			t++;
		end
		chk("tx start", {31'h0, txdOut}, 32'h0);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		apb(0, SLAVE_ADDRESS_IDX, 8'h0);
		chk("addr after reset", rd, 32'h0);
		$display("error, transmit and reset done");
		close_out;
	end
endmodule
